// ---- arc_sensor_model.sv ----
`timescale 1ns/100ps
// ===================
// external unit: binary input level plus short supervision pulses
module arc_sensor_model (
    input wire core_clk,
    input wire pulse_on,
    input wire bi_cmd,
    output wire arc_card_binary_input_one
);
    reg [3:0] cnt_r = 4'h0;
    always @(posedge core_clk) cnt_r <= cnt_r + 4'h1;
    // three-cycle pulse: long enough to pass the pin synchroniser, short of the filter
    assign arc_card_binary_input_one = bi_cmd | (pulse_on & (cnt_r >= 4'hD));
endmodule

// ---- arc_zone_checker_assertions.sv ----
`timescale 1ns/100ps
// ===================
// port checker
module arc_zone_checker (
    input wire core_clk,
    input wire reset_n,
    input wire [3:0] light_pin,
    input wire [3:0] pressure_pin,
    input wire [7:0] sensor_count_pin,
    input wire [7:0] sensor_count_cfg,
    input wire arc_card_binary_input_one,
    input wire test_pulse_ignore,
    input wire [3:0] zone_enable,
    input wire [3:0] zone_block,
    input wire [39:0] zone_config,
    input wire [3:0] light_ind,
    input wire [3:0] pressure_ind,
    input wire arc_bi_ind,
    input wire [3:0] zone_trip,
    input wire [3:0] zone_blocked,
    input wire [3:0] sensor_fault
);
    wire [3:0] fault_exp;
    wire lit0;
    assign fault_exp[0] = sensor_count_pin[1:0] != sensor_count_cfg[1:0];
    assign fault_exp[1] = sensor_count_pin[3:2] != sensor_count_cfg[3:2];
    assign fault_exp[2] = sensor_count_pin[5:4] != sensor_count_cfg[5:4];
    assign fault_exp[3] = sensor_count_pin[7:6] != sensor_count_cfg[7:6];
    assign lit0 = |(light_ind & zone_config[3:0] | pressure_ind & zone_config[7:4]);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    light_follow_a: assert property ($stable(light_pin)[*8] |-> light_ind == light_pin)
        else $error("light indication wrong");
    press_follow_a: assert property ($stable(pressure_pin)[*8] |-> pressure_ind == pressure_pin)
        else $error("pressure indication wrong");
    sensor_fault_a: assert property (($stable(sensor_count_pin) && $stable(sensor_count_cfg))[*8]
        |-> sensor_fault == fault_exp)
        else $error("sensor fault wrong");
    arc_bi_a: assert property ((!test_pulse_ignore && $stable(arc_card_binary_input_one))[*8]
        |-> arc_bi_ind == arc_card_binary_input_one)
        else $error("binary input indication wrong");
    zone_off_a: assert property (((zone_trip | zone_blocked) & ~$past(zone_enable)) == 4'h0)
        else $error("disabled zone active");
    trip_block_a: assert property ((zone_trip & $past(zone_block)) == 4'h0)
        else $error("blocked zone tripped");
    trip_excl_a: assert property ((zone_trip & zone_blocked) == 4'h0)
        else $error("trip and blocked together");
    trip_light_a: assert property (zone_trip[0] |-> lit0 || $past(lit0))
        else $error("zone trip without light");
endmodule

// ---- arc_zone_defs.vh ----
`ifndef ARC_ZONE_DEFS_VH
`define ARC_ZONE_DEFS_VH

`define NUM_CHANNELS 4
`define NUM_ZONES 4
`define MAX_SENSORS 3
`define SAMPLE_WIDTH 16
`define SAMPLE_PERIOD_NS 5000000
`define CLK_PERIOD_NS 5
`define SAMPLE_CYCLES (`SAMPLE_PERIOD_NS / `CLK_PERIOD_NS)
`define PULSE_FILTER_DEFAULT 2000
`define RES_SEL_NONE 2'h0
`define RES_SEL_FIRST 2'h1
`define RES_SEL_SECOND 2'h2
`define REQ_SAMPLES_DEFAULT 4'h3
`define ZCFG_LIGHT_LSB 0
`define ZCFG_PRESS_LSB 4
`define ZCFG_PHASE_BIT 8
`define ZCFG_RES_BIT 9
`define ZCFG_WIDTH 10

`endif

// ---- arc_zone_trip_logic.v ----
`timescale 1ns/100ps
`include "arc_zone_defs.vh"
// Overview of operation
// - four channels, up to three sensors each
// - per-channel light indication output
// - per-channel pressure indication output
// - arc binary input indication while energized
// - phase and residual current start outputs
// - current blocked outputs when measurement blocked and over limit
// - current needs required samples, 5 ms base
// - light per channel assignable to zones
// - pressure assignable to zones like light
// - enabled current requires light plus current
// - phase, residual or both per zone
// - blocked zone shows blocked, never trips
// - sensor fault on connected count mismatch
// - unit fault on external unit mismatch
// - test pulse option suppresses short binary input pulses
// - per-zone enable, disabled means no output
// - residual channel select none/first/second
// - per-channel sensor status OK or fault
module arc_zone_trip_logic #(
    parameter SW = `SAMPLE_WIDTH,
    parameter SAMPLE_CYCLES = `SAMPLE_CYCLES,
    parameter PULSE_FILTER_CYCLES = `PULSE_FILTER_DEFAULT
) (
    input wire core_clk,
    input wire reset_n,
    input wire [3:0] light_pin,
    input wire [3:0] pressure_pin,
    input wire [7:0] sensor_count_pin,
    input wire arc_card_binary_input_one,
    input wire [2:0] unit_count_pin,
    input wire [SW-1:0] phase_a_current,
    input wire [SW-1:0] phase_b_current,
    input wire [SW-1:0] phase_c_current,
    input wire [SW-1:0] residual_channel_first,
    input wire [SW-1:0] residual_channel_second,
    input wire [SW-1:0] phase_limit,
    input wire [SW-1:0] residual_limit,
    input wire [3:0] required_samples,
    input wire [1:0] residual_select,
    input wire phase_block,
    input wire residual_block,
    input wire [3:0] zone_block,
    input wire [3:0] zone_enable,
    input wire [4*`ZCFG_WIDTH-1:0] zone_config,
    input wire [7:0] sensor_count_cfg,
    input wire [2:0] unit_count_cfg,
    input wire test_pulse_ignore,
    output reg [3:0] light_ind,
    output reg [3:0] pressure_ind,
    output reg arc_bi_ind,
    output reg phase_start,
    output reg residual_start,
    output reg phase_blocked,
    output reg residual_blocked,
    output reg [3:0] zone_trip,
    output reg [3:0] zone_blocked,
    output reg [3:0] sensor_fault,
    output reg unit_fault
);
    // =================================================================
    // synchronised pins, one synchroniser per pin group
    wire [3:0] light_s;
    wire [3:0] press_s;
    wire [7:0] count_s;
    wire bi_s;
    wire [2:0] units_s;

    pin_sync3 #(.WIDTH(4)) u_sync_light (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .pin_in(light_pin),
        .level_out(light_s)
    );

    pin_sync3 #(.WIDTH(4)) u_sync_press (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .pin_in(pressure_pin),
        .level_out(press_s)
    );

    pin_sync3 #(.WIDTH(8)) u_sync_count (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .pin_in(sensor_count_pin),
        .level_out(count_s)
    );

    pin_sync3 #(.WIDTH(1)) u_sync_bi (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .pin_in(arc_card_binary_input_one),
        .level_out(bi_s)
    );

    pin_sync3 #(.WIDTH(3)) u_sync_units (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .pin_in(unit_count_pin),
        .level_out(units_s)
    );

    // =================================================================
    // 5 ms processing tick
    // free-running, so the samples of every current channel share one tick
    reg [31:0] tick_cnt_r;
    reg tick_r;

    always @(posedge core_clk) begin
        if (!reset_n) begin
            tick_cnt_r <= 32'h0;
            tick_r <= 1'b0;
        end else if (tick_cnt_r == SAMPLE_CYCLES - 1) begin
            tick_cnt_r <= 32'h0;
            tick_r <= 1'b1;
        end else begin
            tick_cnt_r <= tick_cnt_r + 32'h1;
            tick_r <= 1'b0;
        end
    end

    // =================================================================
    // current conditions
    wire phase_over;
    wire res_over;
    wire [1:0] res_en;

    // select value 3 enables neither residual channel
    assign res_en = {residual_select == `RES_SEL_SECOND,
                     residual_select == `RES_SEL_FIRST};

    current_cond #(.SW(SW), .NCH(3)) u_phase (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .tick(tick_r),
        .samples({phase_c_current, phase_b_current, phase_a_current}),
        .chan_en(3'h7),
        .limit(phase_limit),
        .required(required_samples),
        .active(phase_over)
    );

    current_cond #(.SW(SW), .NCH(2)) u_res (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .tick(tick_r),
        .samples({residual_channel_second, residual_channel_first}),
        .chan_en(res_en),
        .limit(residual_limit),
        .required(required_samples),
        .active(res_over)
    );

    // =================================================================
    // binary input: short test pulses are filtered when option set
    localparam BI_IDLE = 3'h1;
    localparam BI_QUAL = 3'h2;
    localparam BI_HELD = 3'h4;

    reg [2:0] bi_state_r;
    reg [2:0] bi_state_nxt;
    reg [11:0] bi_cnt_r;
    wire bi_valid;

    always @* begin
        bi_state_nxt = bi_state_r;
        case (bi_state_r)
            BI_IDLE: begin
                if (bi_s) begin
                    bi_state_nxt = BI_QUAL;
                end
            end
            BI_QUAL: begin
                if (!bi_s) begin
                    bi_state_nxt = BI_IDLE;
                end else if (bi_cnt_r == PULSE_FILTER_CYCLES[11:0]) begin
                    bi_state_nxt = BI_HELD;
                end
            end
            BI_HELD: begin
                if (!bi_s) begin
                    bi_state_nxt = BI_IDLE;
                end
            end
            default: begin
                bi_state_nxt = BI_IDLE;
            end
        endcase
    end

    always @(posedge core_clk) begin
        if (!reset_n) begin
            bi_state_r <= BI_IDLE;
            bi_cnt_r <= 12'h000;
        end else begin
            bi_state_r <= bi_state_nxt;
            if (bi_state_nxt == BI_QUAL) begin
                bi_cnt_r <= bi_cnt_r + 12'h001;
            end else begin
                bi_cnt_r <= 12'h000;
            end
        end
    end

    // a level must outlast the filter before it counts when pulses are ignored
    assign bi_valid = bi_s && (!test_pulse_ignore || bi_state_r == BI_HELD);

    // =================================================================
    // zone evaluation
    // light or pressure of any channel enabled for the zone
    function zone_light;
        input [`ZCFG_WIDTH-1:0] cfg;
        input [3:0] lt;
        input [3:0] pr;
        begin
            zone_light = |(cfg[`ZCFG_LIGHT_LSB +: 4] & lt) |
                         |(cfg[`ZCFG_PRESS_LSB +: 4] & pr);
        end
    endfunction

    wire [3:0] zone_ok;
    wire [3:0] sens_bad;
    genvar z;
    genvar c;

    generate
        for (z = 0; z < `NUM_ZONES; z = z + 1) begin : g_zone
            wire [`ZCFG_WIDTH-1:0] cfg;
            wire lit;
            wire phase_ok;
            wire res_ok;

            assign cfg = zone_config[z*`ZCFG_WIDTH +: `ZCFG_WIDTH];
            assign lit = zone_light(cfg, light_s, press_s);
            // a blocked current never satisfies a zone
            assign phase_ok = !cfg[`ZCFG_PHASE_BIT] ||
                              (phase_over && !phase_block);
            assign res_ok = !cfg[`ZCFG_RES_BIT] ||
                            (res_over && !residual_block);
            assign zone_ok[z] = zone_enable[z] && lit && phase_ok && res_ok;
        end

        for (c = 0; c < `NUM_CHANNELS; c = c + 1) begin : g_chan
            wire [1:0] seen_cnt;
            wire [1:0] set_cnt;

            assign seen_cnt = count_s[c*2 +: 2];
            assign set_cnt = sensor_count_cfg[c*2 +: 2];
            // a mismatch either way is a configuration fault
            assign sens_bad[c] = seen_cnt != set_cnt;
        end
    endgenerate

    // =================================================================
    // registered outputs
    always @(posedge core_clk) begin
        if (!reset_n) begin
            light_ind <= 4'h0;
            pressure_ind <= 4'h0;
            arc_bi_ind <= 1'b0;
        end else begin
            light_ind <= light_s;
            pressure_ind <= press_s;
            arc_bi_ind <= bi_valid;
        end
    end

    // a blocked measurement shows as blocked, never as started
    always @(posedge core_clk) begin
        if (!reset_n) begin
            phase_start <= 1'b0;
            residual_start <= 1'b0;
            phase_blocked <= 1'b0;
            residual_blocked <= 1'b0;
        end else begin
            phase_start <= phase_over && !phase_block;
            residual_start <= res_over && !residual_block;
            phase_blocked <= phase_over && phase_block;
            residual_blocked <= res_over && residual_block;
        end
    end

    always @(posedge core_clk) begin
        if (!reset_n) begin
            zone_trip <= 4'h0;
            zone_blocked <= 4'h0;
            sensor_fault <= 4'h0;
            unit_fault <= 1'b0;
        end else begin
            zone_trip <= zone_ok & ~zone_block;
            zone_blocked <= zone_ok & zone_block;
            sensor_fault <= sens_bad;
            unit_fault <= units_s != unit_count_cfg;
        end
    end
endmodule

// ---- current_cond.v ----
`timescale 1ns/100ps
`include "arc_zone_defs.vh"
// =====================================================================
// counts consecutive samples above limit on each sample tick
module current_cond #(
    parameter SW = `SAMPLE_WIDTH,
    parameter NCH = 3
) (
    input wire core_clk,
    input wire reset_n,
    input wire tick,
    input wire [NCH*SW-1:0] samples,
    input wire [NCH-1:0] chan_en,
    input wire [SW-1:0] limit,
    input wire [3:0] required,
    output reg active
);
    reg [3:0] count_r;
    reg [NCH-1:0] over;
    integer i;

    always @* begin
        over = {NCH{1'b0}};
        for (i = 0; i < NCH; i = i + 1) begin
            over[i] = chan_en[i] && (samples[i*SW +: SW] > limit);
        end
    end

    always @(posedge core_clk) begin
        if (!reset_n) begin
            count_r <= 4'h0;
            active <= 1'b0;
        end else if (tick) begin
            if (|over) begin
                if (count_r != 4'hF) begin
                    count_r <= count_r + 4'h1;
                end
                // widened so a saturated count keeps the condition active
                active <= (({1'b0, count_r} + 5'h01) >= {1'b0, required}) &&
                          (required != 4'h0);
            end else begin
                count_r <= 4'h0;
                active <= 1'b0;
            end
        end
    end
endmodule

// ---- pin_sync3.v ----
`timescale 1ns/100ps
// =====================================================================
// three-stage pin synchroniser, change accepted when stages 2 and 3 agree
module pin_sync3 #(
    parameter WIDTH = 1
) (
    input wire core_clk,
    input wire reset_n,
    input wire [WIDTH-1:0] pin_in,
    output reg [WIDTH-1:0] level_out
);
    reg [WIDTH-1:0] s1_r;
    reg [WIDTH-1:0] s2_r;
    reg [WIDTH-1:0] s3_r;
    integer i;

    always @(posedge core_clk) begin
        if (!reset_n) begin
            s1_r <= {WIDTH{1'b0}};
            s2_r <= {WIDTH{1'b0}};
            s3_r <= {WIDTH{1'b0}};
            level_out <= {WIDTH{1'b0}};
        end else begin
            s1_r <= pin_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            for (i = 0; i < WIDTH; i = i + 1) begin
                if (s2_r[i] == s3_r[i]) begin
                    level_out[i] <= s3_r[i];
                end
            end
        end
    end
endmodule

// ---- testbench.sv ----
`timescale 1ns/100ps
module testbench;
    reg core_clk = 1'b0;
    reg reset_n = 1'b0;
    reg [3:0] lp = 4'h0, pp = 4'h0, zb = 4'h0, ze = 4'h0, rq = 4'h0, et, ek, ef;
    reg [7:0] sc = 8'h00, scc = 8'h00;
    reg [2:0] uc = 3'h0, ucc = 3'h0;
    reg [1:0] rs = 2'h0;
    reg bi = 1'b0, tpi = 1'b0, pb = 1'b0, rb = 1'b0, ph, rc, hit;
    reg [15:0] cur [0:6];
    reg [39:0] zc = 40'h0;
    reg [9:0] cfg;
    reg [31:0] r;
    wire bip, ab, ps, rsr, pbo, rbo, uf;
    wire [3:0] li, pi, zt, zk, sf;
    integer n_fail = 0, n_compared = 0, cyc = 0, t, z;
    initial for (z = 0; z < 7; z = z + 1) cur[z] = 16'h0100;
    always #2.5 core_clk = ~core_clk;
    arc_sensor_model i_arc_sensor_model (.core_clk(core_clk), .pulse_on(tpi), .bi_cmd(bi),
        .arc_card_binary_input_one(bip));
    arc_zone_trip_logic #(.SAMPLE_CYCLES(10), .PULSE_FILTER_CYCLES(4)) i_arc_zone_trip_logic (
        .core_clk(core_clk), .reset_n(reset_n), .light_pin(lp), .pressure_pin(pp),
        .sensor_count_pin(sc), .arc_card_binary_input_one(bip), .unit_count_pin(uc),
        .phase_a_current(cur[0]), .phase_b_current(cur[1]), .phase_c_current(cur[2]),
        .residual_channel_first(cur[3]), .residual_channel_second(cur[4]),
        .phase_limit(cur[5]), .residual_limit(cur[6]), .required_samples(rq),
        .residual_select(rs), .phase_block(pb), .residual_block(rb), .zone_block(zb),
        .zone_enable(ze), .zone_config(zc), .sensor_count_cfg(scc), .unit_count_cfg(ucc),
        .test_pulse_ignore(tpi), .light_ind(li), .pressure_ind(pi), .arc_bi_ind(ab),
        .phase_start(ps), .residual_start(rsr), .phase_blocked(pbo), .residual_blocked(rbo),
        .zone_trip(zt), .zone_blocked(zk), .sensor_fault(sf), .unit_fault(uf));
    task check(input [31:0] seen, input [31:0] exp);
        begin
            n_compared = n_compared + 1;
            if (seen !== exp) begin
                n_fail = n_fail + 1;
                $display("ERROR t=%0t seen %h exp %h", $time, seen, exp);
            end
        end
    endtask
    task summarize;
        begin
            $display("compared %0d failed %0d", n_compared, n_fail);
            if (n_fail == 0 && n_compared > 0)
                $display("Run complete: PASS");
            else
                $display("Run complete: FAIL");
            $finish;
        end
    endtask
    always @(posedge core_clk) begin
        cyc = cyc + 1;
        if (cyc == 4000) begin
            n_fail = n_fail + 1;
            summarize;
        end
    end
    initial begin
        r = $urandom(75);
        repeat (4) @(negedge core_clk);
        reset_n = 1'b1;
        for (t = 0; t < 40; t = t + 1) begin
            r = $urandom;
            {lp, pp, zb, ze, sc, scc} = r;
            r = $urandom;
            {uc, ucc, rs, bi, tpi, pb, rb} = r[11:0];
            rq = {2'h0, r[13:12]};
            zc = {r[31:24], $urandom};
            for (z = 0; z < 5; z = z + 1) begin
                r = $urandom;
                cur[z] = {8'h00, r[7:0]} + 16'h0080;
            end
            repeat (60) @(negedge core_clk);
            ph = rq != 4'h0 && (cur[0] > cur[5] || cur[1] > cur[5] || cur[2] > cur[5]);
            rc = rq != 4'h0 && (rs == 2'h1 ? cur[3] > cur[6] : rs == 2'h2 && cur[4] > cur[6]);
            for (z = 0; z < 4; z = z + 1) begin
                cfg = zc[z*10 +: 10];
                hit = ze[z] && |(lp & cfg[3:0] | pp & cfg[7:4]) && (!cfg[8] || ph && !pb)
                    && (!cfg[9] || rc && !rb);
                et[z] = hit && !zb[z];
                ek[z] = hit && zb[z];
                ef[z] = sc[2*z +: 2] != scc[2*z +: 2];
            end
            check(li, lp);
            check(pi, pp);
            check(ab, bi);
            check({ps, pbo}, {ph && !pb, ph && pb});
            check({rsr, rbo}, {rc && !rb, rc && rb});
            check(zt, et);
            check(zk, ek);
            check(sf, ef);
            check(uf, uc != ucc);
            $display("test %0d done", t);
        end
        summarize;
    end
endmodule
bind arc_zone_trip_logic arc_zone_checker i_arc_zone_checker (.core_clk, .reset_n,
    .light_pin, .pressure_pin, .sensor_count_pin, .sensor_count_cfg,
    .arc_card_binary_input_one, .test_pulse_ignore, .zone_enable, .zone_block, .zone_config,
    .light_ind, .pressure_ind, .arc_bi_ind, .zone_trip, .zone_blocked, .sensor_fault);
